// file: rtl/crl_defines.vh
// register indices, field positions and reset values of the lock bank
`ifndef CRL_DEFINES_VH
`define CRL_DEFINES_VH
// graphics-port extended indices
`define CRL_IDX_LOCK       8'h0D
`define CRL_IDX_VIDCTL     8'h0E
`define CRL_IDX_STATUS     8'h0F
`define CRL_IDX_FIRST_LO   8'h09
`define CRL_IDX_FIRST_HI   8'h0F
// crtc-port indices
`define CRL_IDX_UNLOCK2    8'h29
`define CRL_IDX_SWITCH     8'h2A
`define CRL_IDX_BANK2_HI   8'h2F
`define CRL_CR_HT_LAST     8'h05
`define CRL_CR_VTOTAL      8'h06
`define CRL_CR_OVERFLOW    8'h07
`define CRL_CR_MAXSCAN     8'h09
`define CRL_CR_VRS         8'h10
`define CRL_CR_VRE         8'h11
`define CRL_CR_SVB         8'h15
`define CRL_CR_EVB         8'h16
`define CRL_CR_MODE        8'h17
// lock control fields
`define CRL_LK_VSPOL       7
`define CRL_LK_HSPOL       6
`define CRL_LK_HTIME       5
`define CRL_LK_ADDR9       4
`define CRL_LK_ADDR8       3
`define CRL_LK_DOUBLE      2
`define CRL_LK_PREVENT     1
`define CRL_LK_VTIME       0
// video control fields
`define CRL_VC_DE          7
`define CRL_VC_PCLK        6
`define CRL_VC_TRIVID      5
`define CRL_VC_TRIMEM      4
`define CRL_VC_CGAOVR      3
`define CRL_VC_EGA         1
`define CRL_VC_SHIFT256    0
// masks, keys and fixed values
`define CRL_OVF_G1_MASK    8'h42
`define CRL_OVF_G2_MASK    8'hAD
`define CRL_MAXSCAN_MASK   8'h20
`define CRL_VRE_LOW_MASK   8'h0F
`define CRL_MODE_DIV2_MASK 8'h04
`define CRL_UNLOCK_KEY     3'b101
`define CRL_RD_KEY_HI      1'b1
`define CRL_RD_KEY_LO      1'b0
`define CRL_PROTECT_BIT    7
`define CRL_RD_LOCKED      8'hFF
`define CRL_RESET_BYTE     8'h00
`define CRL_SELECT_CGA80   1'b1
`endif

// file: rtl/crl_lock_bank.v
// extended lock, unlock and video output control register bank
// What this block does
// - crtc 00..05 writes blocked when horizontal lock or protect bit set
// - overflow bits 6,1 blocked when prevention clear and protect set
// - crtc 06 and overflow bits 7,5,3,2,0 blocked by vertical lock/protect
// - 09 bit5, 10, 11 bits3:0, 15, 16 blocked by vertical lock alone
// - mode register 17 bit 2 blocked by horizontal lock
// - sync polarity bits of misc output held while their locks set
// - lock bits 4,3 give address bits 17,16 for start and cursor
// - lock bit 2 doubles cursor, preset row and max scan values
// - video bit 7 turns blank output into display enable
// - video bit 6 picks raw video clock instead of dot clock
// - video bit 5 floats video data, syncs and blank
// - video bit 4 floats memory address and dram controls
// - video bit 3 forces cga video enable in 80x25 text only
// - ega bit blocks reads of write-only and first seven ext regs
// - video bit 0 selects 256-colour shift register mode
// - first unlock field resets to zero, unlocks only on 101
// - strap bits 7,6,5,4,8 read in status bits 7..3
// - second bank readable only when bit7=1, bit3=0, else FFH
// - second bank writes above unlock need low bits 101
// - unlock bits 6:4 are scratch storage
// - switch register: four switch bits high, four lock bits low
// - force-video-clock keeps horizontal timing at full rate
`timescale 1ns/100ps
`default_nettype none
`include "crl_defines.vh"
module crl_lock_bank #(
    parameter DW = 8
) (
    // clock and reset
    input  wire          CLOCK,
    input  wire          RST,
    // graphics-port extended access
    input  wire          GX_WR,
    input  wire          GX_RD,
    input  wire [7:0]    GX_INDEX,
    input  wire [DW-1:0] GX_WDATA,
    output reg  [DW-1:0] GX_RDATA,
    output reg           GX_RD_HIT,
    // crtc-port access, also seen for standard crtc indices
    input  wire          CR_WR,
    input  wire          CR_RD,
    input  wire [7:0]    CR_INDEX,
    input  wire [DW-1:0] CR_WDATA,
    output reg  [DW-1:0] CR_RDATA,
    output reg           CR_RD_HIT,
    output reg  [DW-1:0] CR_WR_MASK,
    // misc output register write and standard protect state
    input  wire          MISC_WR,
    input  wire          CRTC_PROTECT,
    output reg  [1:0]    SYNC_POL_WR_EN,
    // straps and mode inputs
    input  wire [4:0]    CONFIG_STRAP,
    input  wire [3:0]    SWITCH_STRAP,
    input  wire          CGA_TEXT80,
    input  wire          FORCE_VIDEO_CLOCK_IN,
    input  wire          SEQ_HALF_CLK,
    input  wire [4:0]    CURSOR_START,
    input  wire [4:0]    CURSOR_STOP,
    input  wire [4:0]    PRESET_ROW,
    input  wire [4:0]    MAX_SCAN,
    // video control outputs
    output reg  [1:0]    CHAR_ADDRESS_HIGH,
    output reg  [5:0]    CURSOR_START_EFF,
    output reg  [5:0]    CURSOR_STOP_EFF,
    output reg  [5:0]    PRESET_ROW_EFF,
    output reg  [5:0]    MAX_SCAN_EFF,
    output reg           BLANK_IS_DE,
    output reg           PCLK_IS_VIDEO_CLOCK_IN,
    output reg           VIDEO_OUT_OE,
    output reg           MEM_CTRL_OE,
    output reg           CGA_VIDEO_FORCE,
    output reg           EGA_COMPAT,
    output reg           SHIFT_256,
    output reg           HTIME_FULL_RATE,
    output reg  [3:0]    SWITCH_LOCKS
);

    reg  [7:0] lock_q;
    reg  [7:0] vidctl_q;
    reg  [2:0] unlock1_q;
    reg  [7:0] unlock2_q;
    reg  [7:0] switch_q;
    reg        strap_taken_q;

    wire first_open  = (unlock1_q == `CRL_UNLOCK_KEY);
    wire bank2_write = (unlock2_q[2:0] == `CRL_UNLOCK_KEY);
    wire bank2_read  = (unlock2_q[7] == `CRL_RD_KEY_HI) &&
                       (unlock2_q[3] == `CRL_RD_KEY_LO);
    wire ega         = vidctl_q[`CRL_VC_EGA];
    wire hlock       = lock_q[`CRL_LK_HTIME];
    wire vlock       = lock_q[`CRL_LK_VTIME];

    // double a scan value when the lock bank asks for it
    function [5:0] dbl;
        input [4:0] v;
        input       en;
        begin
            dbl = en ? {v, 1'b0} : {1'b0, v};
        end
    endfunction

    // per-bit write mask for standard crtc indices
    function [7:0] crtc_mask;
        input [7:0] idx;
        input       hl;
        input       vl;
        input       prv;
        input       pro;
        begin
            crtc_mask = 8'hFF;
            if (idx <= `CRL_CR_HT_LAST) begin
                if (hl || pro)
                    crtc_mask = 8'h00;
            end else if (idx == `CRL_CR_VTOTAL) begin
                if (vl || pro)
                    crtc_mask = 8'h00;
            end else if (idx == `CRL_CR_OVERFLOW) begin
                if (!prv && pro)
                    crtc_mask = crtc_mask & ~`CRL_OVF_G1_MASK;
                if (vl || pro)
                    crtc_mask = crtc_mask & ~`CRL_OVF_G2_MASK;
            end else if (idx == `CRL_CR_MAXSCAN) begin
                if (vl)
                    crtc_mask = ~`CRL_MAXSCAN_MASK;
            end else if (idx == `CRL_CR_VRS || idx == `CRL_CR_SVB ||
                         idx == `CRL_CR_EVB) begin
                if (vl)
                    crtc_mask = 8'h00;
            end else if (idx == `CRL_CR_VRE) begin
                if (vl)
                    crtc_mask = ~`CRL_VRE_LOW_MASK;
            end else if (idx == `CRL_CR_MODE) begin
                if (hl)
                    crtc_mask = ~`CRL_MODE_DIV2_MASK;
            end
        end
    endfunction

    // register writes; blocked writes simply fall through
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            lock_q        <= `CRL_RESET_BYTE;
            vidctl_q      <= `CRL_RESET_BYTE;
            unlock1_q     <= 3'b000;
            unlock2_q     <= `CRL_RESET_BYTE;
            switch_q      <= `CRL_RESET_BYTE;
            strap_taken_q <= 1'b0;
        end else begin
            // switch bits are latched once after reset release
            if (!strap_taken_q) begin
                switch_q[7:4] <= SWITCH_STRAP;
                strap_taken_q <= 1'b1;
            end
            if (GX_WR) begin
                if (GX_INDEX == `CRL_IDX_STATUS)
                    unlock1_q <= GX_WDATA[2:0];
                else if (first_open && GX_INDEX == `CRL_IDX_LOCK)
                    lock_q <= GX_WDATA;
                else if (first_open && GX_INDEX == `CRL_IDX_VIDCTL)
                    vidctl_q <= GX_WDATA;
            end
            if (CR_WR) begin
                if (CR_INDEX == `CRL_IDX_UNLOCK2)
                    unlock2_q <= CR_WDATA;
                else if (bank2_write && CR_INDEX == `CRL_IDX_SWITCH)
                    switch_q <= CR_WDATA;
            end
        end
    end

    // read paths, write masks and decoded outputs, all registered
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            GX_RDATA          <= `CRL_RESET_BYTE;
            GX_RD_HIT         <= 1'b0;
            CR_RDATA          <= `CRL_RESET_BYTE;
            CR_RD_HIT         <= 1'b0;
            CR_WR_MASK        <= 8'hFF;
            SYNC_POL_WR_EN    <= 2'b11;
            CHAR_ADDRESS_HIGH <= 2'b00;
            CURSOR_START_EFF  <= 6'h00;
            CURSOR_STOP_EFF   <= 6'h00;
            PRESET_ROW_EFF    <= 6'h00;
            MAX_SCAN_EFF      <= 6'h00;
            BLANK_IS_DE       <= 1'b0;
            PCLK_IS_VIDEO_CLOCK_IN      <= 1'b0;
            VIDEO_OUT_OE      <= 1'b1;
            MEM_CTRL_OE       <= 1'b1;
            CGA_VIDEO_FORCE   <= 1'b0;
            EGA_COMPAT        <= 1'b0;
            SHIFT_256         <= 1'b0;
            HTIME_FULL_RATE   <= 1'b0;
            SWITCH_LOCKS      <= 4'h0;
        end else begin
            GX_RD_HIT <= 1'b0;
            GX_RDATA  <= `CRL_RESET_BYTE;
            // ega mode hides the first seven extended indices, 09 through 0F
            if (GX_RD && !ega && GX_INDEX >= `CRL_IDX_FIRST_LO - 8'h00 &&
                GX_INDEX <= `CRL_IDX_FIRST_HI) begin
                GX_RD_HIT <= 1'b1;
                case (GX_INDEX)
                    `CRL_IDX_LOCK:   GX_RDATA <= lock_q;
                    `CRL_IDX_VIDCTL: GX_RDATA <= vidctl_q;
                    `CRL_IDX_STATUS:
                        GX_RDATA <= {CONFIG_STRAP, unlock1_q};
                    default:         GX_RD_HIT <= 1'b0;
                endcase
            end
            CR_RD_HIT <= 1'b0;
            CR_RDATA  <= `CRL_RESET_BYTE;
            if (CR_RD && CR_INDEX >= `CRL_IDX_UNLOCK2 &&
                CR_INDEX <= `CRL_IDX_BANK2_HI) begin
                CR_RD_HIT <= 1'b1;
                if (!bank2_read)
                    CR_RDATA <= `CRL_RD_LOCKED;
                else if (CR_INDEX == `CRL_IDX_UNLOCK2)
                    CR_RDATA <= unlock2_q;
                else if (CR_INDEX == `CRL_IDX_SWITCH)
                    CR_RDATA <= switch_q;
                else
                    CR_RD_HIT <= 1'b0;
            end
            CR_WR_MASK <= crtc_mask(CR_INDEX, hlock, vlock,
                                    lock_q[`CRL_LK_PREVENT],
                                    CRTC_PROTECT);
            SYNC_POL_WR_EN <= {~lock_q[`CRL_LK_VSPOL],
                               ~lock_q[`CRL_LK_HSPOL]};
            CHAR_ADDRESS_HIGH <= {lock_q[`CRL_LK_ADDR9],
                                  lock_q[`CRL_LK_ADDR8]};
            CURSOR_START_EFF <= dbl(CURSOR_START,
                                    lock_q[`CRL_LK_DOUBLE]);
            CURSOR_STOP_EFF  <= dbl(CURSOR_STOP, lock_q[`CRL_LK_DOUBLE]);
            PRESET_ROW_EFF   <= dbl(PRESET_ROW, lock_q[`CRL_LK_DOUBLE]);
            MAX_SCAN_EFF     <= dbl(MAX_SCAN, lock_q[`CRL_LK_DOUBLE]);
            BLANK_IS_DE      <= vidctl_q[`CRL_VC_DE];
            PCLK_IS_VIDEO_CLOCK_IN     <= vidctl_q[`CRL_VC_PCLK];
            VIDEO_OUT_OE     <= ~vidctl_q[`CRL_VC_TRIVID];
            MEM_CTRL_OE      <= ~vidctl_q[`CRL_VC_TRIMEM];
            CGA_VIDEO_FORCE  <= vidctl_q[`CRL_VC_CGAOVR] &&
                                (CGA_TEXT80 == `CRL_SELECT_CGA80);
            EGA_COMPAT       <= ega;
            SHIFT_256        <= vidctl_q[`CRL_VC_SHIFT256];
            HTIME_FULL_RATE  <= FORCE_VIDEO_CLOCK_IN || !SEQ_HALF_CLK;
            SWITCH_LOCKS     <= switch_q[3:0];
        end
    end

endmodule
`default_nettype wire

// file: testbench/crl_lock_bank_asserts.sv
// port-level assertion checker for the lock bank
`timescale 1ns/100ps
`default_nettype none
module crl_lock_bank_asserts (
    // clock and reset
    input wire logic       CLOCK,
    input wire logic       RST,
    // register ports
    input wire logic       GX_WR,
    input wire logic       GX_RD,
    input wire logic [7:0] GX_INDEX,
    input wire logic [7:0] GX_RDATA,
    input wire logic       GX_RD_HIT,
    input wire logic       CR_WR,
    input wire logic       CR_RD,
    input wire logic [7:0] CR_INDEX,
    input wire logic [7:0] CR_RDATA,
    input wire logic       CR_RD_HIT,
    input wire logic [7:0] CR_WR_MASK,
    // lock state
    input wire logic       CRTC_PROTECT,
    input wire logic [4:0] CONFIG_STRAP,
    input wire logic       EGA_COMPAT
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    sequence s_wr(lo, hi, p);
        CR_WR && CR_INDEX >= lo && CR_INDEX <= hi && p;
    endsequence
    AST_GRP0: assert property (s_wr(8'h00, 8'h05, CRTC_PROTECT)
        |=> CR_WR_MASK == 8'h00) else $error("group 0 write let through");
    AST_GRP1: assert property (s_wr(8'h07, 8'h07, !CRTC_PROTECT)
        |=> CR_WR_MASK[6] && CR_WR_MASK[1]) else $error("group 1 blocked");
    AST_GRP2: assert property (s_wr(8'h06, 8'h06, CRTC_PROTECT)
        |=> CR_WR_MASK == 8'h00) else $error("vertical total let through");
    AST_GRP4: assert property (s_wr(8'h17, 8'h17, 1'b1)
        |=> (CR_WR_MASK | 8'h04) == 8'hFF) else $error("mode reg over-locked");
    AST_EGA_NORD: assert property (GX_RD && !$past(GX_WR) && EGA_COMPAT
        && GX_INDEX >= 8'h0D && GX_INDEX <= 8'h0F |=> !GX_RD_HIT)
        else $error("extended read allowed in ega mode");
    AST_B2_HIT: assert property (CR_RD && CR_INDEX == 8'h29
        |=> CR_RD_HIT) else $error("unlock register read not answered");
    AST_B2_KEY: assert property (CR_RD_HIT && $past(CR_RD)
        && $past(CR_INDEX) == 8'h29 && CR_RDATA != 8'hFF
        |-> CR_RDATA[7] && !CR_RDATA[3]) else $error("bank 2 read leaked");
    AST_STRAPS: assert property (GX_RD_HIT && $past(GX_INDEX) == 8'h0F
        |-> GX_RDATA[7:3] == $past(CONFIG_STRAP)) else $error("strap bits wrong");
endmodule
bind crl_lock_bank crl_lock_bank_asserts u_chk (.CLOCK, .RST, .GX_WR, .GX_RD,
    .GX_INDEX, .GX_RDATA, .GX_RD_HIT, .CR_WR, .CR_RD, .CR_INDEX, .CR_RDATA,
    .CR_RD_HIT, .CR_WR_MASK, .CRTC_PROTECT, .CONFIG_STRAP, .EGA_COMPAT);
`default_nettype wire

// file: testbench/crl_host_model.sv
// host i/o bus model: index writes and reads on either register port
`timescale 1ns/100ps
`default_nettype none
module crl_host_model (
    // clock
    input  wire logic       CLOCK,
    // strobes {crtc rd, crtc wr, gfx rd, gfx wr}, shared index and data
    output var  logic [3:0] STB,
    output var  logic [7:0] IDX,
    output var  logic [7:0] DAT,
    // read data of both ports
    input  wire logic [7:0] GX_RDATA,
    input  wire logic [7:0] CR_RDATA
);
    initial STB = 4'h0;
    task automatic acc(input logic cr, input logic w, input logic [7:0] i,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge CLOCK);
        STB <= cr ? {~w, w, 2'h0} : {2'h0, ~w, w};
        IDX <= i;
        DAT <= d;
        @(posedge CLOCK);
        STB <= 4'h0;
        // released lines show the inverse so a stale value cannot pass
        IDX <= ~i;
        DAT <= ~d;
        #1 q = cr ? CR_RDATA : GX_RDATA;
    endtask
endmodule
`default_nettype wire

// file: testbench/crl_lock_bank_tb.sv
// self-checking bench for the lock bank
`timescale 1ns/100ps
`default_nettype none
module crl_lock_bank_tb;
    logic       clk, rst, prot;
    logic [4:0] strap = 5'h16;
    logic [4:0] sc = 5'h0B;
    logic [3:0] sw = 4'h9;
    logic [7:0] q, v;
    wire  [7:0] idx, dat, grd, crd, mask;
    wire  [5:0] cs, ms;
    wire  [3:0] stb, lk;
    wire  [1:0] sp, cah;
    wire        ghit, chit, de, pv, voe, moe, cgf, ega, s256, hfr;
    int         n_fail = 0;
    int         n_tests = 0;
    int         cyc = 0;
    crl_lock_bank dut (.CLOCK(clk), .RST(rst), .GX_WR(stb[0]), .GX_RD(stb[1]),
        .GX_INDEX(idx), .GX_WDATA(dat), .GX_RDATA(grd), .GX_RD_HIT(ghit),
        .CR_WR(stb[2]), .CR_RD(stb[3]), .CR_INDEX(idx), .CR_WDATA(dat),
        .CR_RDATA(crd), .CR_RD_HIT(chit), .CR_WR_MASK(mask), .MISC_WR(1'b0),
        .CRTC_PROTECT(prot), .SYNC_POL_WR_EN(sp), .CONFIG_STRAP(strap),
        .SWITCH_STRAP(sw), .CGA_TEXT80(1'b1), .FORCE_VIDEO_CLOCK_IN(1'b0),
        .SEQ_HALF_CLK(1'b1), .CURSOR_START(sc), .CURSOR_STOP(sc ^ 5'h01),
        .PRESET_ROW(sc ^ 5'h02), .MAX_SCAN(sc ^ 5'h03),
        .CHAR_ADDRESS_HIGH(cah), .CURSOR_START_EFF(cs), .CURSOR_STOP_EFF(),
        .PRESET_ROW_EFF(), .MAX_SCAN_EFF(ms), .BLANK_IS_DE(de),
        .PCLK_IS_VIDEO_CLOCK_IN(pv), .VIDEO_OUT_OE(voe), .MEM_CTRL_OE(moe),
        .CGA_VIDEO_FORCE(cgf), .EGA_COMPAT(ega), .SHIFT_256(s256),
        .HTIME_FULL_RATE(hfr), .SWITCH_LOCKS(lk));
    crl_host_model host (.CLOCK(clk), .STB(stb), .IDX(idx), .DAT(dat),
        .GX_RDATA(grd), .CR_RDATA(crd));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    // decoded outputs trail the register by one cycle
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic t_vidctl;
        host.acc(1'b0, 1'b0, 8'h0F, 8'h00, q);
        chk("status", {strap, 3'h0}, q);
        host.acc(1'b0, 1'b1, 8'h0E, 8'hF9, q);
        settle();
        chk("oe locked", 8'h03, {6'h00, voe, moe});
        host.acc(1'b0, 1'b1, 8'h0F, 8'hA5, q);
        host.acc(1'b0, 1'b1, 8'h0E, 8'hF9, q);
        host.acc(1'b0, 1'b1, 8'h0F, 8'h04, q);
        host.acc(1'b0, 1'b1, 8'h0E, 8'h00, q);
        settle();
        v = {de, pv, ~voe, ~moe, cgf, hfr, ega, s256};
        chk("video", 8'hF9, v);
        host.acc(1'b0, 1'b0, 8'h0E, 8'h00, q);
        chk("vidctl", 8'hF9, q);
        $display("video control test done");
    endtask
    task automatic t_lock;
        logic [31:0] tab [14] = '{32'h00FD_0300, 32'h00FD_0500, 32'h00FD_0600,
            32'h00FD_0752, 32'h00FD_08FF, 32'h00FD_09DF, 32'h00FD_1000,
            32'h00FD_11F0, 32'h00FD_1600, 32'h00FD_17FB, 32'h0100_0710,
            32'h0102_0752, 32'h0100_0300, 32'h0000_11FF};
        host.acc(1'b0, 1'b1, 8'h0F, 8'h05, q);
        host.acc(1'b0, 1'b1, 8'h0D, 8'hFD, q);
        settle();
        chk("addr hi", 8'h03, {6'h00, cah});
        chk("sync en", 8'h00, {6'h00, sp});
        chk("cursor", {2'h0, sc, 1'b0}, {2'h0, cs});
        foreach (tab[k]) begin
            @(posedge clk) prot <= tab[k][24];
            host.acc(1'b0, 1'b1, 8'h0D, tab[k][23:16], q);
            host.acc(1'b1, 1'b1, tab[k][15:8], 8'hFF, q);
            chk("mask", tab[k][7:0], mask);
        end
        chk("sync free", 8'h03, {6'h00, sp});
        chk("max scan", {3'h0, sc ^ 5'h03}, {2'h0, ms});
        $display("crtc lock test done");
    endtask
    task automatic t_bank2;
        host.acc(1'b1, 1'b0, 8'h29, 8'h00, q);
        chk("unlock2 reset", 8'hFF, q);
        host.acc(1'b1, 1'b1, 8'h29, 8'hF5, q);
        host.acc(1'b1, 1'b0, 8'h29, 8'h00, q);
        chk("unlock2", 8'hF5, q);
        host.acc(1'b1, 1'b0, 8'h2A, 8'h00, q);
        chk("switches", {sw, 4'h0}, q);
        host.acc(1'b1, 1'b1, 8'h2A, 8'h0A, q);
        host.acc(1'b1, 1'b0, 8'h2A, 8'h00, q);
        chk("locks", 8'h0A, {4'h0, lk});
        host.acc(1'b1, 1'b1, 8'h29, 8'h84, q);
        host.acc(1'b1, 1'b1, 8'h2A, 8'h05, q);
        host.acc(1'b1, 1'b0, 8'h2A, 8'h00, q);
        chk("switch kept", 8'h0A, q);
        host.acc(1'b1, 1'b1, 8'h29, 8'h8D, q);
        host.acc(1'b1, 1'b0, 8'h29, 8'h00, q);
        chk("unlock2 hidden", 8'hFF, q);
        host.acc(1'b0, 1'b1, 8'h0E, 8'h02, q);
        host.acc(1'b0, 1'b0, 8'h0D, 8'h00, q);
        chk("ega read", 8'h00, {7'h00, ghit});
        $display("second bank test done");
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        rst = 1'b1;
        prot = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_vidctl();
        t_lock();
        t_bank2();
        stop_test();
    end
endmodule
`default_nettype wire
